// [rtl/point_fifo.v]
// Synchronous FIFO holding finished trace points.
`timescale 1ns/1ps
module point_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_b,
    input wire clkEn,
    // Write side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Read side
    output reg outValid,
    input wire outReady,
    output reg [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr;
    reg [AW:0] rdPtr;
    wire [AW:0] count = wrPtr - rdPtr;
    wire empty = (count == {(AW+1){1'b0}});
    wire loadOut = !empty && (!outValid || outReady);
    wire doWrite = inValid && inReady;
    assign inReady = (count != DEPTH[AW:0]) || (DEPTH == (1 << AW) && count[AW] == 1'b0);

    always @(posedge clk_sys) begin
        if (clkEn && doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= {(AW+1){1'b0}};
            rdPtr <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (loadOut) begin
                outData <= mem[rdPtr[AW-1:0]];
                rdPtr <= rdPtr + 1'b1;
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end
endmodule

// [rtl/trace_pixel_detector.v]
// Video filter and per-point detector producing a fixed-length display trace.
//
// How it works
// - Only unsigned magnitude values enter and leave the block; no phase is carried.
// - A first-order lowpass with a configurable shift sets the video cutoff.
// - The detector reads the filtered value, never the raw input.
// - Each trace has exactly 631 points, each summarising its group of samples.
// - Peak mode outputs the largest value of each group.
// - Auto-peak mode outputs both the largest and the smallest value of each group.
// - RMS mode outputs the root-mean-square of each group.
// - Sample mode outputs the first value of each group and ignores the rest.
`timescale 1ns/1ps
`include "trace_pixel_detector_regs.vh"
module trace_pixel_detector #(
    parameter W = 16,
    parameter POINTS = 631,
    parameter FIFO_DEPTH = 8
) (
    // Clock, reset and enable
    input wire clk_sys,
    input wire rst_b,
    input wire clkEn,
    // Configuration
    input wire [1:0] detMode,
    input wire [3:0] videoShift,
    // Magnitude input stream
    input wire magValid,
    input wire [W-1:0] magData,
    input wire pointEnd,
    output reg magReady,
    // Trace point output stream
    output reg pointValid,
    input wire pointReady,
    output reg [W-1:0] pointMax,
    output reg [W-1:0] pointMin,
    output reg [9:0] pointIndex,
    output reg traceEnd
);
    // ----------------------------------------------------------------
    // State encodings and sum and FIFO word widths
    // ----------------------------------------------------------------
    localparam ST_ACC = 3'b001;
    localparam ST_SQRT = 3'b010;
    localparam ST_PUSH = 3'b100;
    localparam SW = 2 * W + 10;
    localparam FW = 2 * W + 11;

    // ----------------------------------------------------------------
    // Working registers
    // ----------------------------------------------------------------
    reg [2:0] state;
    reg [W+15:0] videoAcc;
    reg [W-1:0] accMax;
    reg [W-1:0] accMin;
    reg [W-1:0] accFirst;
    reg [SW-1:0] accSum;
    reg [9:0] accCount;
    reg haveFirst;
    reg [9:0] pointCnt;
    reg [SW-1:0] rmsRem;
    reg [W-1:0] rmsRoot;
    reg [4:0] rmsStep;
    reg [W-1:0] resHi;
    reg [W-1:0] resLo;
    reg [9:0] resIdx;
    reg resLast;

    // ----------------------------------------------------------------
    // Video filter
    // ----------------------------------------------------------------
    wire take = magValid && magReady && clkEn;
    wire [W+15:0] magWide = {magData, 16'h0000};
    wire [W+15:0] diffUp = (magWide - videoAcc) >> videoShift;
    wire [W+15:0] diffDn = (videoAcc - magWide) >> videoShift;
    wire [W+15:0] next_videoAcc = (magWide >= videoAcc) ? videoAcc + diffUp : videoAcc - diffDn;
    wire [W-1:0] video = next_videoAcc[W+15:16];
    wire [2*W-1:0] videoSq = video * video;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            videoAcc <= {(W+16){1'b0}};
        end else if (take) begin
            videoAcc <= next_videoAcc;
        end
    end

    // ----------------------------------------------------------------
    // Detector accumulation and finishing
    // ----------------------------------------------------------------
    wire fifoReady;
    wire [9:0] cntInc = accCount + 10'h001;
    wire [SW-1:0] sumNext = accSum + {{(SW-2*W){1'b0}}, videoSq};
    wire [W-1:0] maxNext = (!haveFirst || video > accMax) ? video : accMax;
    wire [W-1:0] minNext = (!haveFirst || video < accMin) ? video : accMin;
    wire [W-1:0] firstNext = haveFirst ? accFirst : video;
    wire [SW-1:0] meanSq = sumNext / {{(SW-10){1'b0}}, cntInc};
    wire [W-1:0] trial = rmsRoot | ({{(W-1){1'b0}}, 1'b1} << rmsStep);
    wire [2*W-1:0] trialSq = trial * trial;
    wire lastPoint = (pointCnt == POINTS[9:0] - 10'h001);

    // ----------------------------------------------------------------
    // Boundary and square-root helpers
    // ----------------------------------------------------------------
    wire closePoint = take && pointEnd;
    wire rootFits = ({{(SW-2*W){1'b0}}, trialSq} <= rmsRem);
    wire [W-1:0] rootStep = rootFits ? trial : rmsRoot;
    reg [W-1:0] next_resHi;
    reg [W-1:0] next_resLo;
    reg [2:0] next_state;

    // ----------------------------------------------------------------
    // Result selection at a point boundary
    // ----------------------------------------------------------------
    always @* begin
        next_resHi = resHi;
        next_resLo = resLo;
        next_state = ST_PUSH;
        case (detMode)
            `TPD_MODE_PEAK: begin
                next_resHi = maxNext;
                next_resLo = maxNext;
            end
            `TPD_MODE_AUTOPEAK: begin
                next_resHi = maxNext;
                next_resLo = minNext;
            end
            `TPD_MODE_RMS: begin
                next_state = ST_SQRT;
            end
            `TPD_MODE_SAMPLE: begin
                next_resHi = firstNext;
                next_resLo = firstNext;
            end
            default: begin
                next_resHi = maxNext;
                next_resLo = maxNext;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencing and input handshake
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_ACC;
            magReady <= 1'b0;
        end else if (clkEn) begin
            case (state)
                ST_ACC: begin
                    if (closePoint) begin
                        magReady <= 1'b0;
                        state <= next_state;
                    end else begin
                        magReady <= 1'b1;
                    end
                end
                ST_SQRT: begin
                    if (rmsStep == 5'h00) begin
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (fifoReady) begin
                        state <= ST_ACC;
                        magReady <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_ACC;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-point accumulators
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            accMax <= {W{1'b0}};
            accMin <= {W{1'b0}};
            accFirst <= {W{1'b0}};
            accSum <= {SW{1'b0}};
            accCount <= 10'h000;
            haveFirst <= 1'b0;
        end else if (take) begin
            accMax <= maxNext;
            accMin <= minNext;
            accFirst <= firstNext;
            if (pointEnd) begin
                haveFirst <= 1'b0;
                accSum <= {SW{1'b0}};
                accCount <= 10'h000;
            end else begin
                haveFirst <= 1'b1;
                accSum <= sumNext;
                accCount <= cntInc;
            end
        end
    end

    // ----------------------------------------------------------------
    // Trace point counter
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pointCnt <= 10'h000;
            resIdx <= 10'h000;
            resLast <= 1'b0;
        end else if (closePoint) begin
            resIdx <= pointCnt;
            resLast <= lastPoint;
            pointCnt <= lastPoint ? 10'h000 : pointCnt + 10'h001;
        end
    end

    // ----------------------------------------------------------------
    // Square root of the mean square
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rmsRem <= {SW{1'b0}};
            rmsRoot <= {W{1'b0}};
            rmsStep <= 5'h00;
        end else if (clkEn) begin
            if (closePoint) begin
                rmsRem <= meanSq;
                rmsRoot <= {W{1'b0}};
                rmsStep <= W[4:0] - 5'h01;
            end else if (state == ST_SQRT) begin
                rmsRoot <= rootStep;
                if (rmsStep != 5'h00) begin
                    rmsStep <= rmsStep - 5'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Finished point result
    // ----------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resHi <= {W{1'b0}};
            resLo <= {W{1'b0}};
        end else if (clkEn) begin
            if (closePoint) begin
                resHi <= next_resHi;
                resLo <= next_resLo;
            end else if ((state == ST_SQRT) && (rmsStep == 5'h00)) begin
                resHi <= rootStep;
                resLo <= rootStep;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    wire fifoValid;
    wire [FW-1:0] fifoData;
    wire fifoPush = (state == ST_PUSH);

    point_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) uFifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .inValid(fifoPush),
        .inReady(fifoReady),
        .inData({resLast, resIdx, resHi, resLo}),
        .outValid(fifoValid),
        .outReady(pointReady || !pointValid),
        .outData(fifoData)
    );

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    wire outLoad = fifoValid && (pointReady || !pointValid);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pointValid <= 1'b0;
        end else if (clkEn) begin
            if (outLoad) begin
                pointValid <= 1'b1;
            end else if (pointReady) begin
                pointValid <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pointMax <= {W{1'b0}};
            pointMin <= {W{1'b0}};
            pointIndex <= 10'h000;
            traceEnd <= 1'b0;
        end else if (clkEn && outLoad) begin
            pointMax <= fifoData[2*W-1:W];
            pointMin <= fifoData[W-1:0];
            pointIndex <= fifoData[FW-2:2*W];
            traceEnd <= fifoData[FW-1];
        end
    end
endmodule

// [rtl/trace_pixel_detector_regs.vh]
// Constants shared by the trace pixel detector design files.
`ifndef TRACE_PIXEL_DETECTOR_REGS_VH
`define TRACE_PIXEL_DETECTOR_REGS_VH
`define TPD_POINTS 10'h277
`define TPD_MODE_PEAK 2'h0
`define TPD_MODE_AUTOPEAK 2'h1
`define TPD_MODE_RMS 2'h2
`define TPD_MODE_SAMPLE 2'h3
`define TPD_SHIFT_RESET 4'h0
`define TPD_FIFO_DEPTH 8
`endif

// [test/mag_source.sv]
// Upstream magnitude stream model feeding the detector.
`timescale 1ns/1ps
module mag_source (
    // Clock
    input wire clk_sys,
    // Stream
    input wire magReady,
    output logic magValid,
    output logic [15:0] magData,
    output logic pointEnd
);
    initial begin
        magValid = 1'b0;
        magData = 16'h0;
        pointEnd = 1'b0;
    end
    // Offers one sample and holds it until it is taken.
    task automatic send(input logic [15:0] d, input logic e);
        int k;
        magValid <= 1'b1;
        magData <= d;
        pointEnd <= e;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (magReady !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            trace_pixel_detector_tb.fail_count++;
            trace_pixel_detector_tb.tally_and_finish();
        end
    endtask
    // Releases the stream; data shows the inverse of the last value.
    task automatic idle();
        magValid <= 1'b0;
        pointEnd <= 1'b0;
        magData <= ~magData;
        @(posedge clk_sys);
    endtask
endmodule

// [test/trace_pixel_detector_sva.sv]
// Concurrent checks on the trace pixel detector ports.
`timescale 1ns/1ps
module trace_pixel_detector_sva #(
    parameter W = 16,
    parameter POINTS = 631
) (
    // Clock and control
    input wire clk_sys,
    input wire rst_b,
    input wire clkEn,
    input wire [1:0] detMode,
    input wire [3:0] videoShift,
    // Input stream
    input wire magValid,
    input wire [W-1:0] magData,
    input wire pointEnd,
    input wire magReady,
    // Output stream
    input wire pointValid,
    input wire pointReady,
    input wire [W-1:0] pointMax,
    input wire [W-1:0] pointMin,
    input wire [9:0] pointIndex,
    input wire traceEnd
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    reg [9:0] expIdx;
    // Index the next handed-over point must carry.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            expIdx <= 10'h0;
        end else if (clkEn && pointValid && pointReady) begin
            expIdx <= (expIdx == POINTS - 1) ? 10'h0 : expIdx + 10'h1;
        end
    end
    chk_valid_hold:
        assert property (pointValid && !pointReady |=> pointValid) else $error("point lost");
    chk_data_hold:
        assert property (pointValid && !pointReady |=>
            $stable({pointMax, pointMin, pointIndex, traceEnd})) else $error("point changed");
    chk_pair_order:
        assert property (pointValid |-> pointMin <= pointMax) else $error("min above max");
    chk_index_seq:
        assert property (pointValid |-> pointIndex == expIdx) else $error("index skipped");
    chk_trace_end:
        assert property (pointValid |-> traceEnd == (pointIndex == POINTS - 1))
            else $error("trace end misplaced");
    chk_ready_gap:
        assert property (magValid && magReady && pointEnd && clkEn |=> !magReady)
            else $error("ready back too soon");
    chk_point_due:
        assert property (magValid && magReady && pointEnd && clkEn |-> ##[1:40] pointValid)
            else $error("point late");
    chk_single_value:
        assert property (pointValid && detMode != 2'h1 |-> pointMin == pointMax)
            else $error("min differs");
endmodule
bind trace_pixel_detector trace_pixel_detector_sva #(.W(W), .POINTS(POINTS)) i_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn), .detMode(detMode),
    .videoShift(videoShift), .magValid(magValid), .magData(magData), .pointEnd(pointEnd),
    .magReady(magReady), .pointValid(pointValid), .pointReady(pointReady),
    .pointMax(pointMax), .pointMin(pointMin), .pointIndex(pointIndex), .traceEnd(traceEnd));

// [test/trace_pixel_detector_tb.sv]
// Self-checking testbench for the trace pixel detector.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
module trace_pixel_detector_tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic [1:0] detMode = 2'h0;
    logic [3:0] videoShift = 4'h0;
    logic pointReady = 1'b1;
    wire magValid, magReady, pointEnd, pointValid, traceEnd;
    wire [15:0] magData, pointMax, pointMin;
    wire [9:0] pointIndex;
    int fail_count = 0;
    int compares = 0;
    int nIdx = 0;
    logic [42:0] got[$];
    always #10 clk_sys = ~clk_sys;
    trace_pixel_detector i_trace_pixel_detector (.clk_sys(clk_sys), .rst_b(rst_b),
        .clkEn(clkEn), .detMode(detMode), .videoShift(videoShift), .magValid(magValid),
        .magData(magData), .pointEnd(pointEnd), .magReady(magReady), .pointValid(pointValid),
        .pointReady(pointReady), .pointMax(pointMax), .pointMin(pointMin),
        .pointIndex(pointIndex), .traceEnd(traceEnd));
    mag_source i_mag_source (.clk_sys(clk_sys), .magReady(magReady), .magValid(magValid),
        .magData(magData), .pointEnd(pointEnd));
    always @(posedge clk_sys) begin
        if (clkEn && pointValid && pointReady) begin
            got.push_back({traceEnd, pointIndex, pointMin, pointMax});
        end
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Sends one group of n samples in mode m.
    task automatic grp(input logic [1:0] m, input logic [15:0] a, b, c, input int n);
        detMode <= m;
        for (int i = 0; i < n; i++) begin
            i_mag_source.send(i == 0 ? a : (i == 1 ? b : c), i == n - 1);
        end
        i_mag_source.idle();
    endtask
    // Waits for one point and judges value, index and trace end.
    task automatic take(input logic [15:0] eMax, input logic [15:0] eMin);
        int k;
        logic [42:0] p;
        k = 0;
        while (got.size() == 0 && k < 500) begin
            @(posedge clk_sys);
            k++;
        end
        if (got.size() == 0) begin
            fail_count++;
            tally_and_finish();
        end
        p = got.pop_front();
        `CHK("max", eMax, p[15:0])
        `CHK("min", eMin, p[31:16])
        `CHK("index", nIdx[9:0], p[41:32])
        `CHK("end", nIdx == 630, p[42])
        nIdx = (nIdx == 630) ? 0 : nIdx + 1;
    endtask
    task automatic t_peak();
        grp(2'h0, 16'h5, 16'h40, 16'h7, 3);
        take(16'h40, 16'h40);
        grp(2'h0, 16'h3, 16'h2, 16'h0, 2);
        take(16'h3, 16'h3);
    endtask
    task automatic t_modes();
        grp(2'h1, 16'h9, 16'h32, 16'h4, 3);
        take(16'h32, 16'h4);
        grp(2'h2, 16'h6, 16'h8, 16'h0, 2);
        take(16'h7, 16'h7);
        grp(2'h3, 16'h4d, 16'hc8, 16'h1, 3);
        take(16'h4d, 16'h4d);
    endtask
    task automatic t_filter();
        grp(2'h3, 16'h64, 16'h0, 16'h0, 1);
        take(16'h64, 16'h64);
        videoShift <= 4'h1;
        grp(2'h3, 16'h12c, 16'h0, 16'h0, 1);
        take(16'hc8, 16'hc8);
        videoShift <= 4'h0;
    endtask
    task automatic t_freeze();
        pointReady <= 1'b0;
        grp(2'h0, 16'h2a, 16'h0, 16'h0, 1);
        repeat (6) @(posedge clk_sys);
        clkEn <= 1'b0;
        pointReady <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK("frozen", 1'b1, pointValid)
        `CHK("kept", 0, got.size())
        clkEn <= 1'b1;
        take(16'h2a, 16'h2a);
    endtask
    task automatic t_fill();
        pointReady <= 1'b0;
        fork
            for (int i = 1; i <= 12; i++) grp(2'h0, i[15:0], 16'h0, 16'h0, 1);
        join_none
        repeat (100) @(posedge clk_sys);
        `CHK("refuse", 1'b0, magReady)
        `CHK("held", 0, got.size())
        pointReady <= 1'b1;
        wait fork;
        for (int i = 1; i <= 12; i++) take(i[15:0], i[15:0]);
    endtask
    task automatic t_wrap();
        int n;
        n = 632 - nIdx;
        for (int i = 0; i < n; i++) begin
            grp(2'h0, i[15:0], 16'h0, 16'h0, 1);
            take(i[15:0], i[15:0]);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_peak();
        t_modes();
        t_filter();
        t_freeze();
        t_fill();
        t_wrap();
        tally_and_finish();
    end
endmodule
